//--- inc/rsu_pkg.sv
// Constants, register map and carrier types of the right shift unit.
// Assumes one 250 MHz core clock and an AXI4-Lite master with 32-bit data.
package rsu_pkg;

  // Register byte offsets.
  localparam logic [7:0] RSU_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] RSU_INSTR_OFFSET = 8'h04;
  localparam logic [7:0] RSU_COUNT_OFFSET = 8'h08;
  localparam logic [7:0] RSU_OPERAND_OFFSET = 8'h0C;
  localparam logic [7:0] RSU_RESULT_OFFSET = 8'h10;
  localparam logic [7:0] RSU_FLAGS_OFFSET = 8'h14;
  localparam logic [7:0] RSU_STATUS_OFFSET = 8'h18;

  // Field positions.
  localparam int RSU_START_BIT = 0;
  localparam int RSU_BUSY_BIT = 0;
  localparam int RSU_DONE_BIT = 1;
  localparam int RSU_BAD_OPCODE_BIT = 2;
  localparam int RSU_BAD_COUNT_BIT = 3;
  localparam int RSU_DST_LSB = 4;
  localparam int RSU_OPC_WORD_BIT = 8;
  localparam int RSU_OPC_ARITH_BIT = 3;
  localparam int RSU_OPC_LONG_BIT = 2;

  // Fixed opcode fields of the shift group.
  localparam logic [6:0] RSU_OPC_PREFIX = 7'h59;
  localparam logic [1:0] RSU_OPC_TAIL = 2'h1;

  // Largest legal count per operand size.
  localparam logic [15:0] RSU_MAX_BYTE = 16'h0008;
  localparam logic [15:0] RSU_MAX_WORD = 16'h0010;
  localparam logic [15:0] RSU_MAX_LONG = 16'h0020;

  // Execution time is setup plus steps times the count.
  localparam logic [7:0] RSU_SETUP_CYCLES = 8'h0D;
  localparam logic [7:0] RSU_STEP_CYCLES = 8'h03;

  // Reset values.
  localparam logic [31:0] RSU_WORD_RESET = 32'h0000_0000;
  localparam logic [15:0] RSU_HALF_RESET = 16'h0000;
  localparam logic [5:0] RSU_FLAGS_RESET = 6'h00;

  localparam logic [1:0] RSU_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSU_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RSU_SIZE_BYTE,
    RSU_SIZE_WORD,
    RSU_SIZE_LONG
  } rsu_size_type;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } rsu_flags_type;

  typedef struct packed {
    logic valid;
    logic arith;
    rsu_size_type size;
    logic [3:0] dst;
  } rsu_decode_type;

endpackage

//--- design/rsu_right_shift_unit.sv
// Right shift unit: arithmetic and zero-fill right shifts of byte, word
// and long operands, with flag results and count-dependent timing.
// Assumes an AXI4-Lite master on core_clk; inputs are synchronous to it.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Arithmetic shift moves bits toward bit zero and copies the sign bit.
// - Counts allowed: byte up to 8, word up to 16, long up to 32.
// - Count zero leaves destination unchanged; zero and sign flags still come from it, carry keeps its value.
// - Carry takes each bit leaving position zero; ends as last bit out.
// - Zero flag set exactly when the final result is all zeros.
// - Arithmetic shift sets sign flag when the result is negative.
// - Zero-fill shift loads zero into the top bit at every step.
// - Zero-fill shift sign flag copies the result's top bit.
// - Both shifts take 13 plus 3 times count cycles; zero counts as one.
// - Count arrives negated in sixteen bits; the unit negates it back.
module rsu_right_shift_unit
  import rsu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  typedef enum logic {
    RSU_IDLE,
    RSU_RUN
  } rsu_state_type;

  rsu_state_type state;
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic start_req;
  logic [15:0] instr_word;
  logic [15:0] count_word;
  logic [31:0] operand;
  logic [31:0] result;
  logic [31:0] work;
  rsu_flags_type flags;
  rsu_decode_type cur_op;
  rsu_decode_type next_op;
  logic [15:0] next_count;
  logic [15:0] size_limit;
  logic count_ok;
  logic [7:0] next_total;
  logic [7:0] cyc_cnt;
  logic [5:0] steps_left;
  logic carry;
  logic done;
  logic bad_opcode;
  logic bad_count;
  logic busy;
  logic [32:0] stepped;
  logic [31:0] rd_value;
  logic rd_mapped;
  logic wr_mapped;

  // Recognises the shift group; bit 3 picks arithmetic, bit 2 picks long.
  function automatic rsu_decode_type decode_op(input logic [15:0] op);
    rsu_decode_type d;
    d.valid = (op[15:9] == RSU_OPC_PREFIX) && (op[1:0] == RSU_OPC_TAIL)
      && !(op[RSU_OPC_LONG_BIT] && !op[RSU_OPC_WORD_BIT]);
    d.arith = op[RSU_OPC_ARITH_BIT];
    if (op[RSU_OPC_LONG_BIT]) begin
      d.size = RSU_SIZE_LONG;
    end else if (op[RSU_OPC_WORD_BIT]) begin
      d.size = RSU_SIZE_WORD;
    end else begin
      d.size = RSU_SIZE_BYTE;
    end
    d.dst = op[7:4];
    return d;
  endfunction

  // One step; bits above the operand size are kept as they were.
  function automatic logic [32:0] shift_step(input logic [31:0] v,
                                             input rsu_size_type sz,
                                             input logic arith);
    logic [32:0] r;
    case (sz)
      RSU_SIZE_BYTE: r = {v[0], v[31:8], arith & v[7], v[7:1]};
      RSU_SIZE_WORD: r = {v[0], v[31:16], arith & v[15], v[15:1]};
      default: r = {v[0], arith & v[31], v[31:1]};
    endcase
    return r;
  endfunction

  function automatic logic top_bit(input logic [31:0] v,
                                   input rsu_size_type sz);
    logic t;
    case (sz)
      RSU_SIZE_BYTE: t = v[7];
      RSU_SIZE_WORD: t = v[15];
      default: t = v[31];
    endcase
    return t;
  endfunction

  function automatic logic all_zero(input logic [31:0] v,
                                    input rsu_size_type sz);
    logic z;
    case (sz)
      RSU_SIZE_BYTE: z = (v[7:0] == 8'h00);
      RSU_SIZE_WORD: z = (v[15:0] == 16'h0000);
      default: z = (v == 32'h0000_0000);
    endcase
    return z;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Write address and data are taken in any order, then committed together.
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign arready = !rvalid;
  assign busy = (state == RSU_RUN);

  always_comb begin
    case (wr_addr)
      RSU_CTRL_OFFSET, RSU_INSTR_OFFSET, RSU_COUNT_OFFSET,
      RSU_OPERAND_OFFSET, RSU_RESULT_OFFSET, RSU_FLAGS_OFFSET,
      RSU_STATUS_OFFSET: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= RSU_WORD_RESET;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RSU_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? RSU_RESP_OKAY : RSU_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Plain storage registers written by software.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_word <= RSU_HALF_RESET;
      count_word <= RSU_HALF_RESET;
      operand <= RSU_WORD_RESET;
    end else if (wr_fire) begin
      case (wr_addr)
        RSU_INSTR_OFFSET: instr_word <= 16'(merge({16'h0000, instr_word},
                                                  wr_data, wr_strb));
        RSU_COUNT_OFFSET: count_word <= 16'(merge({16'h0000, count_word},
                                                  wr_data, wr_strb));
        RSU_OPERAND_OFFSET: operand <= merge(operand, wr_data, wr_strb);
        default: ;
      endcase
    end
  end

  // A start while busy is ignored; the run in progress is not disturbed.
  assign start_req = wr_fire && (wr_addr == RSU_CTRL_OFFSET) && wr_strb[0]
    && wr_data[RSU_START_BIT] && !busy;

  assign next_op = decode_op(instr_word);
  assign next_count = 16'(~count_word + 16'h0001);

  always_comb begin
    case (next_op.size)
      RSU_SIZE_BYTE: size_limit = RSU_MAX_BYTE;
      RSU_SIZE_WORD: size_limit = RSU_MAX_WORD;
      default: size_limit = RSU_MAX_LONG;
    endcase
  end

  // Out-of-range counts are refused rather than run with undefined results.
  assign count_ok = (next_count <= size_limit);

  always_comb begin
    if (next_count[5:0] == 6'h00) begin
      next_total = 8'(RSU_SETUP_CYCLES + RSU_STEP_CYCLES);
    end else begin
      next_total = 8'(RSU_SETUP_CYCLES
        + RSU_STEP_CYCLES * {2'h0, next_count[5:0]});
    end
  end

  assign stepped = shift_step(work, cur_op.size, cur_op.arith);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RSU_IDLE;
      cyc_cnt <= 8'h00;
    end else begin
      case (state)
        RSU_IDLE: begin
          if (start_req && next_op.valid && count_ok) begin
            state <= RSU_RUN;
            cyc_cnt <= next_total;
          end
        end
        RSU_RUN: begin
          cyc_cnt <= 8'(cyc_cnt - 8'h01);
          if (cyc_cnt == 8'h01) begin
            state <= RSU_IDLE;
          end
        end
        default: state <= RSU_IDLE;
      endcase
    end
  end

  // The shifting finishes well inside the timed window; the window alone
  // decides when the result becomes visible.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      work <= RSU_WORD_RESET;
      steps_left <= 6'h00;
      carry <= 1'b0;
      cur_op <= '0;
    end else if (start_req) begin
      work <= operand;
      steps_left <= next_count[5:0];
      carry <= flags.c;
      cur_op <= next_op;
    end else if (busy && steps_left != 6'h00) begin
      work <= stepped[31:0];
      carry <= stepped[32];
      steps_left <= 6'(steps_left - 6'h01);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= RSU_WORD_RESET;
    end else if (busy && cyc_cnt == 8'h01) begin
      result <= work;
    end
  end

  // Flags: the end of a run takes priority over a software write.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= RSU_FLAGS_RESET;
    end else if (busy && cyc_cnt == 8'h01) begin
      flags.c <= carry;
      flags.z <= all_zero(work, cur_op.size);
      flags.s <= top_bit(work, cur_op.size);
      if (cur_op.arith) begin
        flags.v <= 1'b0;
      end
    end else if (wr_fire && wr_addr == RSU_FLAGS_OFFSET && wr_strb[0]) begin
      flags <= rsu_flags_type'(wr_data[5:0]);
    end
  end

  // Done is set at the end of a run and cleared by the next start taken while idle, refused or not.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      bad_opcode <= 1'b0;
      bad_count <= 1'b0;
    end else if (busy && cyc_cnt == 8'h01) begin
      done <= 1'b1;
    end else if (start_req) begin
      done <= 1'b0;
      bad_opcode <= !next_op.valid;
      bad_count <= next_op.valid && !count_ok;
    end
  end

  always_comb begin
    rd_mapped = 1'b1;
    rd_value = RSU_WORD_RESET;
    case (araddr)
      RSU_CTRL_OFFSET: rd_value = RSU_WORD_RESET;
      RSU_INSTR_OFFSET: rd_value = {16'h0000, instr_word};
      RSU_COUNT_OFFSET: rd_value = {16'h0000, count_word};
      RSU_OPERAND_OFFSET: rd_value = operand;
      RSU_RESULT_OFFSET: rd_value = result;
      RSU_FLAGS_OFFSET: rd_value = {26'h0, flags};
      RSU_STATUS_OFFSET: begin
        rd_value[RSU_BUSY_BIT] = busy;
        rd_value[RSU_DONE_BIT] = done;
        rd_value[RSU_BAD_OPCODE_BIT] = bad_opcode;
        rd_value[RSU_BAD_COUNT_BIT] = bad_count;
        rd_value[RSU_DST_LSB +: 4] = cur_op.dst;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= RSU_WORD_RESET;
      rresp <= RSU_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_value;
      rresp <= rd_mapped ? RSU_RESP_OKAY : RSU_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- test/rsu_right_shift_unit_properties.sv
// Port-level checks of the right shift unit's register interface.
// Assumes it is bound into rsu_right_shift_unit and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module rsu_right_shift_unit_properties
  import rsu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  logic [7:0] rd_addr;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr <= 8'h00;
    end else if (arvalid && arready) begin
      rd_addr <= araddr;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_AR_GATED: assert property (arready == !rvalid)
    else $error("arready is not the inverse of rvalid");
  AST_W_REFUSED: assert property (bvalid |-> !awready && !wready)
    else $error("write channels open while a response waits");
  AST_B_STANDS: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp))
    else $error("write response dropped or changed before bready");
  AST_R_STANDS: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped or changed before rready");
  AST_B_TIMING: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after the request");
  AST_R_TIMING: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after the request");
  AST_CTRL_READS_ZERO: assert property ($rose(rvalid) &&
    rd_addr == RSU_CTRL_OFFSET |-> rdata == 32'h0000_0000)
    else $error("control word did not read back as zero");
  AST_RESP_CODE: assert property (rvalid |-> rresp == ((rd_addr <=
    RSU_STATUS_OFFSET && rd_addr[1:0] == 2'h0) ? RSU_RESP_OKAY
    : RSU_RESP_SLVERR))
    else $error("read response code does not match the address");
  AST_STATUS_SHAPE: assert property ($rose(rvalid) &&
    rd_addr == RSU_STATUS_OFFSET |-> rdata[31:8] == 24'h0
    && !(rdata[0] && rdata[1]))
    else $error("status shows busy and done together");
endmodule
bind rsu_right_shift_unit rsu_right_shift_unit_properties chk_u (.*);
`default_nettype wire

//--- test/rsu_axi_master.sv
// AXI4-Lite master standing in for the software side of the unit.
// Assumes each task is entered just after a rising edge of core_clk.
`timescale 1ns/100ps
`default_nettype none
module rsu_axi_master (
  input wire logic core_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Released payloads turn to their inverse so a stale copy cannot pass.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- test/right_shift_unit_tb.sv
// Self-checking bench of the right shift unit over its register port.
// Assumes the master model and the bound property checker.
`timescale 1ns/100ps
`default_nettype none
module right_shift_unit_tb;
  import rsu_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] awprot = 3'h0;
  logic [2:0] arprot = 3'h0;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  rsu_right_shift_unit dut_u (.*);
  rsu_axi_master bus_u (.*);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Returns the flags above the full 32-bit result word.
  function automatic logic [37:0] model(input logic [31:0] op, input int n,
      input int w, input logic ar, input logic [5:0] f);
    logic [31:0] m, x;
    logic c;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1;
    x = op & m;
    if (ar && x[w-1]) x = x | ~m;
    c = (n == 0) ? f[5] : x[n-1];
    x = ar ? 32'($signed(x) >>> n) : x >> n;
    return {c, (x & m) == 32'h0, x[w-1], ar ? 1'b0 : f[2], f[1:0],
      (op & ~m) | (x & m)};
  endfunction
  // Kind 1 is a count one past the limit, kind 2 a broken opcode tail.
  task automatic run(input logic ar, input int sz, input int n, input int bad);
    int w, t;
    logic [31:0] op;
    logic [5:0] f;
    logic [3:0] dst;
    logic [15:0] opc;
    logic [37:0] e;
    w = 8 << sz;
    op = $urandom;
    f = 6'($urandom);
    dst = 4'($urandom);
    opc = {RSU_OPC_PREFIX, sz != 0, dst, ar, sz == 2, RSU_OPC_TAIL};
    if (bad == 2) opc[1:0] = 2'h2;
    if (bad == 1) n = w + 1;
    e = model(op, n, w, ar, f);
    bus_u.wr(RSU_INSTR_OFFSET, {16'h0, opc}, r);
    bus_u.wr(RSU_COUNT_OFFSET, {16'h0, 16'(-n)}, r);
    bus_u.wr(RSU_OPERAND_OFFSET, op, r);
    bus_u.wr(RSU_FLAGS_OFFSET, {26'h0, f}, r);
    bus_u.wr(RSU_CTRL_OFFSET, 32'h1, r);
    t = cyc;
    if (bad != 0) begin
      bus_u.rd(RSU_STATUS_OFFSET, d, r);
      check(32'(d[3:0]), bad == 1 ? 32'h8 : 32'h4);
      return;
    end
    do bus_u.rd(RSU_STATUS_OFFSET, d, r);
    while (d[RSU_BUSY_BIT] === 1'b1 && cyc - t < 400);
    t = cyc - t - 13 - 3 * (n == 0 ? 1 : n);
    check(32'(t >= 0 && t <= 4), 32'h1);
    check(d, {24'h0, dst, 4'h2});
    bus_u.rd(RSU_RESULT_OFFSET, d, r);
    check(d, e[31:0]);
    bus_u.rd(RSU_FLAGS_OFFSET, d, r);
    check(d, {26'h0, e[37:32]});
  endtask
  initial begin
    d = $urandom(79439);
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus_u.rd(RSU_STATUS_OFFSET, d, r);
    check(d, 32'h0);
    bus_u.rd(8'h1C, d, r);
    check(32'(r), 32'(RSU_RESP_SLVERR));
    bus_u.wr(8'h20, 32'h1, r);
    check(32'(r), 32'(RSU_RESP_SLVERR));
    bus_u.rd(RSU_CTRL_OFFSET, d, r);
    check(d, 32'h0);
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 3; s++) begin
        run(k[0], s, 0, 0);
        run(k[0], s, 8 << s, 0);
        run(k[0], s, 1, 0);
        run(k[0], s, $urandom_range(8 << s), 0);
        run(k[0], s, 1, 1);
        run(k[0], s, 1, 2);
      end
    end
    summarize();
  end
  initial begin
    #80000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
